// ===== rtl/hpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_top (
    // clock and reset (resetn is the power-on reset)
    input wire logic clk,
    input wire logic resetn,
    // external chip reset pin, active low
    input wire logic ext_reset_n,
    // strap pins shared with downstream data lines
    input wire logic [1:0] port_dplus_disable_strap,
    input wire logic [1:0] port_dminus_disable_strap,
    // upstream power detect pin
    input wire logic upstream_power_detect,
    // port control pins, three signals each; oe low while driving
    input wire logic port1_power_ctl_in,
    output logic port1_power_ctl_out,
    output logic port1_power_ctl_oe_n,
    input wire logic port2_power_ctl_in,
    output logic port2_power_ctl_out,
    output logic port2_power_ctl_oe_n,
    // control from hub firmware
    input wire logic [1:0] port_ctl_output_mode,
    input wire logic [1:0] port_power_request,
    // status to hub
    output logic [1:0] port_disabled,
    output logic upstream_power_present,
    output logic renegotiate_req,
    output logic [1:0] port_overcurrent,
    output logic chip_in_reset
);
    hpc_pkg::hpc_state_t state_q;
    hpc_pkg::hpc_state_t state_d;
    logic [1:0] dp_strap_q;
    logic [1:0] dm_strap_q;
    logic [1:0] power_q;
    logic [1:0] oc_q;
    logic vbus_q;
    logic reneg_q;
    logic ext_level;
    logic ext_rise;
    logic vbus_level;
    logic [1:0] ctl_level;
    logic [1:0] dp_level;
    logic [1:0] dm_level;
    wire [1:0] ctl_pin_in = {port2_power_ctl_in, port1_power_ctl_in};

    hpc_sync u_sync_ext (
        .clk(clk),
        .resetn(resetn),
        .pin_in(ext_reset_n),
        .level_out(ext_level),
        .rise_out(ext_rise),
        .fall_out()
    );

    hpc_sync u_sync_vbus (
        .clk(clk),
        .resetn(resetn),
        .pin_in(upstream_power_detect),
        .level_out(vbus_level),
        .rise_out(),
        .fall_out()
    );

    // per-port pin synchronisers: straps and the shared power control pins
    // all arrive from outside the clock domain

    genvar gi;
    generate
        for (gi = 0; gi < hpc_pkg::HPC_PORTS; gi++) begin : g_port
            hpc_sync u_sync_dp (
                .clk(clk),
                .resetn(resetn),
                .pin_in(port_dplus_disable_strap[gi]),
                .level_out(dp_level[gi]),
                .rise_out(),
                .fall_out()
            );
            hpc_sync u_sync_dm (
                .clk(clk),
                .resetn(resetn),
                .pin_in(port_dminus_disable_strap[gi]),
                .level_out(dm_level[gi]),
                .rise_out(),
                .fall_out()
            );
            hpc_sync u_sync_ctl (
                .clk(clk),
                .resetn(resetn),
                .pin_in(ctl_pin_in[gi]),
                .level_out(ctl_level[gi]),
                .rise_out(),
                .fall_out()
            );
        end
    endgenerate

    // first capture once the synchronisers have settled after power-on
    // the ext reset synchroniser leaves reset low although the pin idles
    // high, so its first rise after power-on is not a real release
    logic [2:0] settle_q;
    wire settled = (settle_q == hpc_pkg::HPC_SETTLE_DONE);
    wire capture = (state_q == hpc_pkg::HPC_ST_POR && settled)
        || ext_rise;
    wire in_reset = (state_q != hpc_pkg::HPC_ST_RUN) || !ext_level;

    always_comb begin
        state_d = state_q;
        case (state_q)
            hpc_pkg::HPC_ST_POR: begin
                if (settled) begin
                    state_d = ext_level ? hpc_pkg::HPC_ST_RUN : hpc_pkg::HPC_ST_RESET;
                end
            end
            // level, not edge: a rise that lands during settle must not strand us here
            hpc_pkg::HPC_ST_RESET: begin
                if (ext_level) begin
                    state_d = hpc_pkg::HPC_ST_RUN;
                end
            end
            hpc_pkg::HPC_ST_RUN: begin
                if (!ext_level) begin
                    state_d = hpc_pkg::HPC_ST_RESET;
                end
            end
            default: state_d = hpc_pkg::HPC_ST_POR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= hpc_pkg::HPC_ST_POR;
            settle_q <= 3'h0;
        end else begin
            state_q <= state_d;
            if (!settled) begin
                settle_q <= settle_q + 3'h1;
            end
        end
    end

    // straps held between captures whatever the shared pins do later
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dp_strap_q <= hpc_pkg::HPC_STRAP_RST;
            dm_strap_q <= hpc_pkg::HPC_STRAP_RST;
        end else if (capture) begin
            dp_strap_q <= dp_level;
            dm_strap_q <= dm_level;
        end
    end

    // a port is disabled only when both of its straps are set
    always_ff @(posedge clk) begin
        if (!resetn) begin
            port_disabled <= 2'h0;
        end else begin
            port_disabled <= dp_strap_q & dm_strap_q;
        end
    end

    // power coming back asks for renegotiation; no reset is issued
    // pulse lines up with present rising, so the hub sees power with it
    // a toggle only counts outside reset, the hub cannot act on it there
    always_ff @(posedge clk) begin
        if (!resetn) begin
            vbus_q <= 1'h0;
            reneg_q <= 1'h0;
        end else begin
            vbus_q <= vbus_level;
            reneg_q <= vbus_level && !vbus_q && !in_reset;
        end
    end

    // ports that the straps leave enabled, optionally gated by reset
    function automatic logic [1:0] live_ports(input logic [1:0] disabled,
            input logic busy);
        live_ports = ~disabled & {2{!busy}};
    endfunction : live_ports

    // power only to enabled, non-disabled output-mode ports outside reset
    wire [1:0] power_d = port_power_request & port_ctl_output_mode
        & live_ports(port_disabled, in_reset);
    // overcurrent sense is low active on an input-mode pin with pull-up
    // reported even in reset: a shorted port must never look healthy
    wire [1:0] oc_d = ~port_ctl_output_mode & ~ctl_level
        & live_ports(port_disabled, 1'b0);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            power_q <= 2'h0;
            oc_q <= 2'h0;
        end else begin
            power_q <= power_d;
            oc_q <= oc_d;
        end
    end

    // pin only driven in output mode; high level enables the port
    assign port1_power_ctl_out = power_q[0];
    assign port2_power_ctl_out = power_q[1];
    assign port1_power_ctl_oe_n = ~port_ctl_output_mode[0];
    assign port2_power_ctl_oe_n = ~port_ctl_output_mode[1];
    assign port_overcurrent = oc_q;
    assign upstream_power_present = vbus_q;
    assign renegotiate_req = reneg_q;
    assign chip_in_reset = in_reset;
endmodule : hpc_top
`default_nettype wire

// ===== rtl/hpc_pkg.sv
package hpc_pkg;
    localparam int HPC_PORTS = 2;
    // synchroniser depth for pin inputs
    localparam int HPC_SYNC_STAGES = 3;
    // reset values
    localparam logic [1:0] HPC_STRAP_RST = 2'h0;
    localparam logic HPC_PIN_RST = 1'h0;
    // cycles after power-on release before the first capture; the strap
    // synchronisers need four edges before their level output is valid
    localparam logic [2:0] HPC_SETTLE_DONE = 3'h4;
    // cycles that the renegotiate request pulse lasts
    localparam int HPC_RENEG_CYCLES = 1;
    // overcurrent stretch figures in ns; unused, hpc_top reports overcurrent with no stretch
    localparam int HPC_CLK_PERIOD_NS = 4;
    localparam int HPC_OC_FILTER_NS = 40;
    localparam int HPC_OC_FILTER_CYCLES = (HPC_OC_FILTER_NS + HPC_CLK_PERIOD_NS - 1)
        / HPC_CLK_PERIOD_NS;
    localparam int HPC_OC_CNT_W = 4;
    typedef enum logic [1:0] {
        HPC_ST_POR = 2'h0,
        HPC_ST_RESET = 2'h1,
        HPC_ST_RUN = 2'h2
    } hpc_state_t;
endpackage : hpc_pkg

// ===== rtl/hpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change counts once stages two and three agree
module hpc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pin side
    input wire logic pin_in,
    // clock domain side
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    wire agree = (s2_q == s3_q);
    wire level_d = agree ? s3_q : level_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= hpc_pkg::HPC_PIN_RST;
            s2_q <= hpc_pkg::HPC_PIN_RST;
            s3_q <= hpc_pkg::HPC_PIN_RST;
            level_q <= hpc_pkg::HPC_PIN_RST;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;
    assign rise_out = level_d & ~level_q;
    assign fall_out = ~level_d & level_q;
endmodule : hpc_sync
`default_nettype wire

// ===== bench/hpc_power_switch.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_power_switch (
    // device side of the pin
    input wire logic drive,
    input wire logic drive_oe_n,
    // overcurrent command
    input wire logic fault,
    // pin level
    output logic pin
);
    // device drive wins when enabled; otherwise the pull-up wins unless the monitor pulls low
    assign pin = !drive_oe_n ? drive : !fault;
endmodule : hpc_power_switch
`default_nettype wire

// ===== bench/hpc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_properties (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ext_reset_n,
    // pins
    input wire logic upstream_power_detect,
    input wire logic port1_power_ctl_in,
    input wire logic port1_power_ctl_out,
    input wire logic port1_power_ctl_oe_n,
    // control and status
    input wire logic [1:0] port_ctl_output_mode,
    input wire logic [1:0] port_power_request,
    input wire logic [1:0] port_disabled,
    input wire logic upstream_power_present,
    input wire logic renegotiate_req,
    input wire logic [1:0] port_overcurrent,
    input wire logic chip_in_reset
);
    logic [3:0] calm_q;
    // saturates well after any capture could land
    always_ff @(posedge clk) begin
        if (!resetn || !ext_reset_n) calm_q <= 4'h0;
        else if (calm_q != 4'hF) calm_q <= calm_q + 4'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_oc_held;
        (!port1_power_ctl_in && !port_ctl_output_mode[0] && !port_disabled[0]
            && !chip_in_reset)[*7];
    endsequence
    sequence s_asked;
        port_power_request[0] && port_ctl_output_mode[0] && !port_disabled[0] && !chip_in_reset;
    endsequence
    chk_strap_hold: assert property (calm_q == 4'hF |-> $stable(port_disabled))
        else $error("strap latch moved");
    chk_power_on: assert property (s_asked |=> port1_power_ctl_out)
        else $error("power not enabled");
    chk_drive_mode: assert property (port1_power_ctl_oe_n == !port_ctl_output_mode[0])
        else $error("drive enable wrong");
    chk_detect_high: assert property (upstream_power_detect[*8] |-> upstream_power_present)
        else $error("power present missing");
    chk_detect_low: assert property (!upstream_power_detect[*8] |-> !upstream_power_present)
        else $error("power present stuck");
    chk_reneg_pulse: assert property (renegotiate_req |->
        (upstream_power_present && !chip_in_reset) ##1 !renegotiate_req)
        else $error("renegotiate pulse wrong");
    chk_oc_report: assert property (s_oc_held |-> port_overcurrent[0])
        else $error("overcurrent missed");
    chk_disabled_dark: assert property (port_disabled[0] && $past(port_disabled[0]) |->
        !port1_power_ctl_out && !port_overcurrent[0])
        else $error("disabled port active");
    chk_reset_quiet: assert property (!ext_reset_n[*6] |-> chip_in_reset && !port1_power_ctl_out)
        else $error("ext reset ignored");
endmodule : hpc_properties
bind hpc_top hpc_properties i_props (.clk, .resetn, .ext_reset_n, .upstream_power_detect,
    .port1_power_ctl_in, .port1_power_ctl_out, .port1_power_ctl_oe_n, .port_ctl_output_mode,
    .port_power_request, .port_disabled, .upstream_power_present, .renegotiate_req,
    .port_overcurrent, .chip_in_reset);
`default_nettype wire

// ===== bench/test_hub_port_power_strap_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_hub_port_power_strap_control;
    logic clk, resetn, ext_reset_n, detect, chk_now, present, reneg, in_rst;
    logic [1:0] dp, dm, mode, req, fault, out, oe_n, pin, dis, oc, cap;
    logic [9:0] exp_q[$];
    logic [9:0] want;
    int fail_count = 0, checks = 0, cycles = 0, seed = 32'hff35, pulses = 0;
    hpc_top i_dut (.clk(clk), .resetn(resetn), .ext_reset_n(ext_reset_n),
        .port_dplus_disable_strap(dp), .port_dminus_disable_strap(dm),
        .upstream_power_detect(detect), .port1_power_ctl_in(pin[0]),
        .port1_power_ctl_out(out[0]), .port1_power_ctl_oe_n(oe_n[0]),
        .port2_power_ctl_in(pin[1]), .port2_power_ctl_out(out[1]),
        .port2_power_ctl_oe_n(oe_n[1]), .port_ctl_output_mode(mode),
        .port_power_request(req), .port_disabled(dis), .upstream_power_present(present),
        .renegotiate_req(reneg), .port_overcurrent(oc), .chip_in_reset(in_rst));
    for (genvar g = 0; g < 2; g++) begin : g_sw
        hpc_power_switch i_sw (.drive(out[g]), .drive_oe_n(oe_n[g]), .fault(fault[g]),
            .pin(pin[g]));
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic expect_now(input logic [9:0] e);
        exp_q.push_back(e);
        chk_now = 1'b1;
        @(negedge clk);
        chk_now = 1'b0;
    endtask : expect_now
    always @(posedge clk) begin
        cycles++;
        if (reneg === 1'b1) pulses++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
        if (chk_now) begin
            want = exp_q.pop_front();
            `CMP({dis, oc, present, out, oe_n, in_rst}, want)
        end
    end
    initial begin
        {resetn, detect, chk_now, mode, req, fault} = '0;
        ext_reset_n = 1'b1;
        {dp, dm} = 4'($random(seed));
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 10; i++) begin
            cap = dp & dm;
            repeat (14) @(negedge clk);
            // pins wander after the latch
            {dp, dm} = 4'($random(seed));
            {req, fault} = 4'($random(seed));
            mode = 2'h3;
            repeat (3) @(negedge clk);
            expect_now({cap, 2'h0, detect, req & ~cap, 2'h0, 1'b0});
            mode = 2'h0;
            // toggle power detect well outside ext reset so renegotiation is seen
            detect = i[0];
            repeat (8) @(negedge clk);
            expect_now({cap, fault & ~cap, detect, 2'h0, 2'h3, 1'b0});
            ext_reset_n = 1'b0;
            repeat (6) @(negedge clk);
            ext_reset_n = 1'b1;
        end
        `CMP(pulses, 5)
        tally_and_finish();
    end
endmodule : test_hub_port_power_strap_control
`default_nettype wire
